// file: include/pwm_sync_update_map.svh
`ifndef PWM_SYNC_UPDATE_MAP_SVH
`define PWM_SYNC_UPDATE_MAP_SVH
// Register byte addresses
`define SYNC_MODE_ADDR 32'h40094020
`define SYNC_TRIGGER_ADDR 32'h40094028
`define SYNC_PERIOD_ADDR 32'h4009402c
`define SYNC_PERIOD_BUF_ADDR 32'h40094030
`define IRQ2_ENABLE_ADDR 32'h40094034
`define IRQ2_DISABLE_ADDR 32'h40094038
`define IRQ2_MASK_ADDR 32'h4009403c
`define IRQ2_STATUS_ADDR 32'h40094040
// Mode register fields
`define SYNC_CH_MSB 7
`define MODE_LSB 16
`define MODE_MSB 17
`define REQ_MODE_BIT 20
`define CMP_SEL_LSB 21
`define CMP_SEL_MSB 23
// Trigger and period fields
`define UNLOCK_BIT 0
`define UPR_LSB 0
`define UPR_MSB 3
`define UPDATE_PERIOD_COUNTER_LSB 4
`define UPDATE_PERIOD_COUNTER_MSB 7
// Group-2 status layout
`define ST_WRITE_READY_FLAG 0
`define ST_DMA_END_OF_TX_FLAG 1
`define ST_DMA_TX_BUFFER_EMPTY_FLAG 2
`define ST_UPDATE_UNDERRUN_FLAG 3
`define CMPM_LSB 8
`define CMPM_MSB 15
`define CMPU_LSB 16
`define CMPU_MSB 23
`define IRQ2_VALID 32'h00ffff0f
`define READ_CLEAR 32'h00ffff09
// Reset values
`define ZERO32 32'h00000000
`define UPR_RESET 4'h0
`define SYNC_CH_RESET 8'h00
`define CMP_SEL_RESET 3'h0
`define DUTY_RESET 16'h0000
`endif

// file: include/pwm_sync_update_pkg.sv
package pwm_sync_update_pkg;
   typedef enum logic [1:0] {
      manual_write_manual_update = 2'h0,
      manual_write_auto_update = 2'h1,
      dma_write_auto_update = 2'h2,
      sync_mode_reserved = 2'h3
   } sync_update_mode_t;
   typedef struct packed {
      logic [31:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } dma_write_t;
endpackage

// file: logic/pwm_sync_update_ctrl.sv
// Contract
// - Mode field: manual, manual/auto, DMA/auto, reserved
// - DMA mode takes duty values from DMA
// - Manual mode applies at period start after unlock
// - Auto modes apply when update period elapses
// - Mode 0 never sets write-ready or request
// - Mode 1 sets write-ready on elapse only
// - Mode 2, request mode 0: both on elapse
// - Mode 2, request mode 1: both on match
// - Compare select picks the matching unit
// - Mode 0 unlock updates period, duty, dead-time
// - Auto modes unlock updates period, dead-time only
// - Unlock self-clears when done; writing 0 ignored
// - Auto updates spaced update period plus one
// - Counter readable beside the period value
// - Period changes go through write-only buffer
// - Enable register sets mask bits by layout
// - Disable register clears mask bits
// - Mask register reads current enables
// - Status read clears write-ready, underrun, compare
// - Write-ready means new values may be written
// - Underrun flag sticky until status read
`include "pwm_sync_update_map.svh"
module pwm_sync_update_ctrl
   import pwm_sync_update_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // APB slave
   input wire apb_req_t apb_req_i,
   output apb_rsp_t apb_rsp_o,
   // Synchronous channel events
   input wire logic period_start_i,
   input wire logic underrun_i,
   input wire logic [7:0] cmp_match_i,
   input wire logic [7:0] cmp_update_i,
   // Peripheral DMA controller
   input wire dma_write_t dma_write_i,
   input wire logic dma_end_of_tx_i,
   input wire logic dma_tx_buffer_empty_i,
   output logic dma_req_o,
   // Update controls
   output logic [7:0] sync_channels_o,
   output logic apply_period_o,
   output logic apply_duty_o,
   output logic [15:0] duty_value_o,
   output logic irq_o
);
   sync_update_mode_t sync_update_mode;
   logic dma_request_mode;
   logic [2:0] dma_request_compare_select;
   logic [7:0] sync_channels;
   logic sync_update_unlock;
   logic [3:0] update_period_value;
   logic [3:0] update_period_counter;
   logic [3:0] update_period_buffer;
   logic buffer_pending;
   logic [31:0] irq_mask;
   logic [31:0] irq_status;
   logic [31:0] rdata;
   logic slverr;
   logic [31:0] next_rdata;
   logic next_hit;
   logic [31:0] next_status;
   logic [31:0] status_set;
   logic [31:0] status_clr;
   logic setup;
   logic wr;
   logic rd_status;
   logic auto_mode;
   logic elapsed;
   logic write_ready_set;
   logic unlock_wr;
   logic wr_mode;
   logic wr_period_buf;
   logic wr_enable;
   logic wr_disable;

   assign setup = apb_req_i.psel & ~apb_req_i.penable;
   assign wr = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
   assign wr_mode = wr & (apb_req_i.paddr == `SYNC_MODE_ADDR);
   assign wr_period_buf = wr & (apb_req_i.paddr == `SYNC_PERIOD_BUF_ADDR);
   assign wr_enable = wr & (apb_req_i.paddr == `IRQ2_ENABLE_ADDR);
   assign wr_disable = wr & (apb_req_i.paddr == `IRQ2_DISABLE_ADDR);
   // Writing 0 to the unlock bit does nothing
   assign unlock_wr = wr & (apb_req_i.paddr == `SYNC_TRIGGER_ADDR) &
      apb_req_i.pwdata[`UNLOCK_BIT];
   assign rd_status = setup & ~apb_req_i.pwrite &
      (apb_req_i.paddr == `IRQ2_STATUS_ADDR);

   // Auto modes only; reserved mode does nothing
   assign auto_mode = (sync_update_mode == manual_write_auto_update) |
      (sync_update_mode == dma_write_auto_update);
   assign elapsed = period_start_i & auto_mode &
      (update_period_counter == update_period_value);

   // Write-ready source by mode and request mode
   always_comb begin
      case (sync_update_mode)
         manual_write_auto_update: begin
            write_ready_set = elapsed;
         end
         dma_write_auto_update: begin
            if (dma_request_mode) begin
               write_ready_set = cmp_match_i[dma_request_compare_select];
            end else begin
               write_ready_set = elapsed;
            end
         end
         default: begin
            write_ready_set = 1'b0;
         end
      endcase
   end

   // Mode register
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sync_update_mode <= manual_write_manual_update;
         dma_request_mode <= 1'b0;
         dma_request_compare_select <= `CMP_SEL_RESET;
         sync_channels <= `SYNC_CH_RESET;
      end else if (wr_mode) begin
         sync_update_mode <= sync_update_mode_t'(apb_req_i.pwdata[`MODE_MSB:`MODE_LSB]);
         dma_request_mode <= apb_req_i.pwdata[`REQ_MODE_BIT];
         dma_request_compare_select <= apb_req_i.pwdata[`CMP_SEL_MSB:`CMP_SEL_LSB];
         sync_channels <= apb_req_i.pwdata[`SYNC_CH_MSB:0];
      end
   end

   assign sync_channels_o = sync_channels;

   // Unlock: a new write wins over the self-clear
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sync_update_unlock <= 1'b0;
      end else if (unlock_wr) begin
         sync_update_unlock <= 1'b1;
      end else if (period_start_i) begin
         sync_update_unlock <= 1'b0;
      end
   end

   // Update period counter
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         update_period_counter <= `UPR_RESET;
      end else if (!auto_mode) begin
         update_period_counter <= `UPR_RESET;
      end else if (elapsed) begin
         update_period_counter <= `UPR_RESET;
      end else if (period_start_i) begin
         update_period_counter <= update_period_counter + 4'h1;
      end
   end

   // Period value moves from buffer only at a safe point
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         update_period_value <= `UPR_RESET;
      end else if (buffer_pending && (elapsed || !auto_mode)) begin
         update_period_value <= update_period_buffer;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         update_period_buffer <= `UPR_RESET;
      end else if (wr_period_buf) begin
         update_period_buffer <= apb_req_i.pwdata[`UPR_MSB:`UPR_LSB];
      end
   end

   // A write in the transfer cycle keeps the new value pending
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         buffer_pending <= 1'b0;
      end else if (wr_period_buf) begin
         buffer_pending <= 1'b1;
      end else if (elapsed || !auto_mode) begin
         buffer_pending <= 1'b0;
      end
   end

   // Update strobes to the channel logic
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         apply_period_o <= 1'b0;
      end else begin
         apply_period_o <= period_start_i & sync_update_unlock;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         apply_duty_o <= 1'b0;
      end else if (sync_update_mode == manual_write_manual_update) begin
         apply_duty_o <= period_start_i & sync_update_unlock;
      end else begin
         apply_duty_o <= elapsed;
      end
   end

   // DMA request and duty value
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         dma_req_o <= 1'b0;
      end else begin
         dma_req_o <= write_ready_set &
            (sync_update_mode == dma_write_auto_update);
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         duty_value_o <= `DUTY_RESET;
      end else if (dma_write_i.valid &&
            (sync_update_mode == dma_write_auto_update)) begin
         duty_value_o <= dma_write_i.data;
      end
   end

   // Interrupt mask
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_mask <= `ZERO32;
      end else if (wr_enable) begin
         irq_mask <= irq_mask | (apb_req_i.pwdata & `IRQ2_VALID);
      end else if (wr_disable) begin
         irq_mask <= irq_mask & ~(apb_req_i.pwdata & `IRQ2_VALID);
      end
   end

   // Sticky status; a set wins over the read clear
   always_comb begin
      status_set = `ZERO32;
      status_set[`ST_WRITE_READY_FLAG] = write_ready_set;
      status_set[`ST_UPDATE_UNDERRUN_FLAG] = underrun_i;
      status_set[`CMPM_MSB:`CMPM_LSB] = cmp_match_i;
      status_set[`CMPU_MSB:`CMPU_LSB] = cmp_update_i;
      status_clr = rd_status ? `READ_CLEAR : `ZERO32;
      next_status = (irq_status & ~status_clr) | status_set;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_status <= `ZERO32;
      end else begin
         irq_status <= next_status;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_status & irq_mask) |
            (dma_end_of_tx_i & irq_mask[`ST_DMA_END_OF_TX_FLAG]) |
            (dma_tx_buffer_empty_i & irq_mask[`ST_DMA_TX_BUFFER_EMPTY_FLAG]);
      end
   end

   // Read mux; write-only registers read as zero
   always_comb begin
      next_rdata = `ZERO32;
      next_hit = 1'b1;
      case (apb_req_i.paddr)
         `SYNC_MODE_ADDR: begin
            next_rdata[`SYNC_CH_MSB:0] = sync_channels;
            next_rdata[`MODE_MSB:`MODE_LSB] = sync_update_mode;
            next_rdata[`REQ_MODE_BIT] = dma_request_mode;
            next_rdata[`CMP_SEL_MSB:`CMP_SEL_LSB] = dma_request_compare_select;
         end
         `SYNC_TRIGGER_ADDR: begin
            next_rdata[`UNLOCK_BIT] = sync_update_unlock;
         end
         `SYNC_PERIOD_ADDR: begin
            next_rdata[`UPR_MSB:`UPR_LSB] = update_period_value;
            next_rdata[`UPDATE_PERIOD_COUNTER_MSB:`UPDATE_PERIOD_COUNTER_LSB] = update_period_counter;
         end
         `SYNC_PERIOD_BUF_ADDR, `IRQ2_ENABLE_ADDR, `IRQ2_DISABLE_ADDR: begin
            next_rdata = `ZERO32;
         end
         `IRQ2_MASK_ADDR: begin
            next_rdata = irq_mask;
         end
         `IRQ2_STATUS_ADDR: begin
            next_rdata = irq_status;
            next_rdata[`ST_DMA_END_OF_TX_FLAG] = dma_end_of_tx_i;
            next_rdata[`ST_DMA_TX_BUFFER_EMPTY_FLAG] = dma_tx_buffer_empty_i;
         end
         default: begin
            next_hit = 1'b0;
         end
      endcase
   end

   // Answer is prepared in the setup cycle
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata <= `ZERO32;
         slverr <= 1'b0;
      end else if (setup) begin
         rdata <= apb_req_i.pwrite ? `ZERO32 : next_rdata;
         slverr <= ~next_hit;
      end
   end

   assign apb_rsp_o = '{prdata: rdata, pready: 1'b1, pslverr: slverr};

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   AST_MANUAL_WRITE_MANUAL_UPDATE_NO_REQ: assert property (
      (sync_update_mode == manual_write_manual_update) |=> !dma_req_o)
      else $error("request raised in manual mode");
   AST_MANUAL_WRITE_MANUAL_UPDATE_NO_WRITE_READY_FLAG: assert property (
      (sync_update_mode == manual_write_manual_update) && !irq_status[`ST_WRITE_READY_FLAG]
      && !wr_mode |=> !irq_status[`ST_WRITE_READY_FLAG])
      else $error("write-ready set in manual mode");
   AST_MANUAL_WRITE_AUTO_UPDATE_WRITE_READY_FLAG: assert property (
      (sync_update_mode == manual_write_auto_update) && elapsed
      |=> irq_status[`ST_WRITE_READY_FLAG] && !dma_req_o)
      else $error("mode 1 elapse handling wrong");
   AST_DMA_WRITE_AUTO_UPDATE_ELAPSE: assert property (
      (sync_update_mode == dma_write_auto_update) && !dma_request_mode && elapsed
      |=> dma_req_o && irq_status[`ST_WRITE_READY_FLAG])
      else $error("mode 2 elapse request missing");
   AST_DMA_WRITE_AUTO_UPDATE_MATCH: assert property (
      (sync_update_mode == dma_write_auto_update) && dma_request_mode &&
      cmp_match_i[dma_request_compare_select] |=> dma_req_o)
      else $error("mode 2 match request missing");
   AST_MANUAL_APPLY: assert property (
      (sync_update_mode == manual_write_manual_update) && sync_update_unlock &&
      period_start_i |=> apply_duty_o && apply_period_o)
      else $error("manual unlock did not apply");
   AST_AUTO_UNLOCK: assert property (
      auto_mode && sync_update_unlock && period_start_i && !elapsed
      |=> apply_period_o && !apply_duty_o)
      else $error("auto unlock applied duty");
   AST_UNLOCK_CLEAR: assert property (
      sync_update_unlock && period_start_i && !unlock_wr |=> !sync_update_unlock)
      else $error("unlock did not clear");
   AST_COUNTER_STEP: assert property (
      period_start_i && auto_mode && !elapsed && !wr_mode
      |=> update_period_counter == $past(update_period_counter) + 4'h1)
      else $error("counter did not step");
   AST_COUNTER_WRAP: assert property (
      elapsed && !wr_mode |=> update_period_counter == `UPR_RESET && apply_duty_o)
      else $error("counter did not wrap on elapse");
   AST_READ_CLEAR: assert property (
      rd_status && !underrun_i |=> !irq_status[`ST_UPDATE_UNDERRUN_FLAG])
      else $error("underrun not cleared by read");
   AST_MASK_ENABLE: assert property (
      wr_enable && apb_req_i.pwdata[`ST_WRITE_READY_FLAG] |=> irq_mask[`ST_WRITE_READY_FLAG])
      else $error("enable write ignored");
   AST_MASK_DISABLE: assert property (
      wr_disable && apb_req_i.pwdata[`ST_UPDATE_UNDERRUN_FLAG] |=> !irq_mask[`ST_UPDATE_UNDERRUN_FLAG])
      else $error("disable write ignored");
   AST_IRQ_OUT: assert property (
      (irq_status[`ST_WRITE_READY_FLAG] && irq_mask[`ST_WRITE_READY_FLAG]) |=> irq_o)
      else $error("interrupt not raised");
endmodule

// file: testbench/dma_partner_model.sv
module dma_partner_model
   import pwm_sync_update_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Request side
   input wire logic req_i,
   input wire logic slow_i,
   // Write side
   output dma_write_t wr_o,
   output logic end_tx_o,
   output logic buf_empty_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy;
   logic [3:0] wait_cnt;
   logic [15:0] word;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         busy <= 1'b0;
         wait_cnt <= 4'h0;
         wr_o <= '0;
         word <= 16'h1234;
         end_tx_o <= 1'b0;
      end else begin
         // Data line toggles when not carrying a word
         wr_o.valid <= 1'b0;
         wr_o.data <= ~wr_o.data;
         if (req_i && !busy) begin
            busy <= 1'b1;
            wait_cnt <= slow_i ? 4'h5 : 4'h0;
         end else if (busy && wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
         end else if (busy) begin
            busy <= 1'b0;
            wr_o.valid <= 1'b1;
            wr_o.data <= word;
            word <= word + 16'h1111;
            end_tx_o <= 1'b1;
         end
      end
   end
   assign buf_empty_o = !busy;
endmodule

// file: testbench/tb.sv
`include "pwm_sync_update_map.svh"
module tb
   import pwm_sync_update_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, reset_i, period_start, underrun, dma_end, dma_empty, dma_req, slow;
   logic apply_per, apply_duty, irq;
   logic [7:0] cmp_match, cmp_update, sync_ch, n_duty, n_per, n_req, sy;
   logic [15:0] duty_val, last_dma;
   logic [31:0] m;
   logic [2:0] sel, oth;
   logic [32:0] q[$];
   apb_req_t apb_req;
   apb_rsp_t apb_rsp;
   dma_write_t dma_write;
   int n_errors, checks_done, cyc;
   integer seed;
   pwm_sync_update_ctrl pwm_sync_update_ctrl_i (.clk_i(clk_i), .reset_i(reset_i),
      .apb_req_i(apb_req), .apb_rsp_o(apb_rsp), .period_start_i(period_start),
      .underrun_i(underrun), .cmp_match_i(cmp_match), .cmp_update_i(cmp_update),
      .dma_write_i(dma_write), .dma_end_of_tx_i(dma_end), .dma_tx_buffer_empty_i(dma_empty),
      .dma_req_o(dma_req), .sync_channels_o(sync_ch), .apply_period_o(apply_per),
      .apply_duty_o(apply_duty), .duty_value_o(duty_val), .irq_o(irq));
   dma_partner_model dma_partner_model_i (.clk_i(clk_i), .reset_i(reset_i), .req_i(dma_req),
      .slow_i(slow), .wr_o(dma_write), .end_tx_o(dma_end), .buf_empty_o(dma_empty));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic close_out();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
      @(posedge clk_i);
      apb_req.penable <= 1'b1;
      do @(posedge clk_i); while (apb_rsp.pready !== 1'b1);
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic er = 1'b0);
      q.push_back({er, e});
      apb(1'b0, a, 32'h0);
   endtask
   task automatic ev(input logic ps, input logic ur, input logic [7:0] cm, input logic [7:0] cu);
      @(posedge clk_i);
      {period_start, underrun, cmp_match, cmp_update} <= {ps, ur, cm, cu};
      @(posedge clk_i);
      {period_start, underrun, cmp_match, cmp_update} <= 18'h0;
   endtask
   task automatic cnt(input logic [7:0] ed, input logic [7:0] ep, input logic [7:0] er);
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      chk({9'h0, n_duty, n_per, n_req}, {9'h0, ed, ep, er}, "pulse counts");
      n_duty = 8'h0;
      n_per = 8'h0;
      n_req = 8'h0;
   endtask
   function automatic logic [31:0] mw(logic [1:0] md, logic r, logic [2:0] s, logic [7:0] y);
      mw = {8'h0, s, r, 2'h0, md, 8'h0, y};
   endfunction
   function automatic logic [31:0] dmab();
      dmab = {29'h0, dma_empty, dma_end, 1'b0};
   endfunction
   // Read answers checked against the oldest expectation
   always @(posedge clk_i) begin
      if (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_rsp.pready === 1'b1) begin
         if (q.size() == 0) chk(33'h0, 33'h1, "unexpected read");
         else chk({apb_rsp.pslverr, apb_rsp.prdata}, q.pop_front(), "read");
      end
   end
   always @(posedge clk_i) begin
      if (!reset_i) begin
         n_duty <= n_duty + 8'(apply_duty);
         n_per <= n_per + 8'(apply_per);
         n_req <= n_req + 8'(dma_req);
      end
      if (dma_write.valid === 1'b1) last_dma <= dma_write.data;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 8000) begin
         n_errors++;
         close_out();
      end
   end
   initial begin
      seed = 32'h72b46d6f;
      {n_errors, checks_done, cyc} = '0;
      {n_duty, n_per, n_req} = '0;
      apb_req = '0;
      {period_start, underrun, cmp_match, cmp_update, slow} = '0;
      last_dma = 16'h0;
      reset_i = 1'b1;
      repeat (10) @(posedge clk_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         rd(`SYNC_MODE_ADDR + 32'(i * 4), (i == 8) ? 32'h4 : 32'h0, i == 1 || i == 9);
      end
      m = $random(seed);
      wr(`IRQ2_ENABLE_ADDR, m);
      wr(`IRQ2_MASK_ADDR, 32'hffffffff);
      rd(`IRQ2_MASK_ADDR, m & 32'h00ffff0f);
      wr(`IRQ2_DISABLE_ADDR, m & 32'h0000ff00);
      rd(`IRQ2_MASK_ADDR, m & 32'h00ff000f);
      wr(`IRQ2_DISABLE_ADDR, 32'hffffffff);
      wr(`IRQ2_ENABLE_ADDR, 32'h1);
      rd(`IRQ2_MASK_ADDR, 32'h1);
      // Manual write, automatic update every three periods
      wr(`SYNC_PERIOD_BUF_ADDR, 32'h2);
      rd(`SYNC_PERIOD_ADDR, 32'h2);
      sy = 8'($random(seed));
      wr(`SYNC_MODE_ADDR, mw(2'h1, 1'b0, 3'h0, sy));
      ev(1'b1, 1'b0, 8'h0, 8'h0);
      rd(`SYNC_PERIOD_ADDR, 32'h12);
      repeat (5) ev(1'b1, 1'b0, 8'h0, 8'h0);
      cnt(8'h2, 8'h0, 8'h0);
      chk({25'h0, sync_ch}, {25'h0, sy}, "sync channels");
      chk({32'h0, irq}, 33'h1, "irq");
      rd(`IRQ2_STATUS_ADDR, 32'h1 | dmab());
      rd(`IRQ2_STATUS_ADDR, dmab());
      cnt(8'h0, 8'h0, 8'h0);
      chk({32'h0, irq}, 33'h0, "irq");
      // Live buffer-empty level raises the interrupt once enabled
      wr(`IRQ2_ENABLE_ADDR, 32'h4);
      rd(`IRQ2_MASK_ADDR, 32'h5);
      chk({32'h0, irq}, {32'h0, dma_empty}, "irq live");
      wr(`IRQ2_DISABLE_ADDR, 32'h4);
      // Manual update needs the unlock bit
      sel = 3'($random(seed));
      oth = sel + 3'h1;
      wr(`SYNC_MODE_ADDR, mw(2'h0, 1'b1, sel, sy));
      ev(1'b1, 1'b0, 8'h1 << sel, 8'h0);
      cnt(8'h0, 8'h0, 8'h0);
      wr(`SYNC_TRIGGER_ADDR, 32'h0);
      rd(`SYNC_TRIGGER_ADDR, 32'h0);
      wr(`SYNC_TRIGGER_ADDR, 32'h1);
      rd(`SYNC_TRIGGER_ADDR, 32'h1);
      ev(1'b1, 1'b0, 8'h0, 8'h0);
      cnt(8'h1, 8'h1, 8'h0);
      rd(`SYNC_TRIGGER_ADDR, 32'h0);
      rd(`IRQ2_STATUS_ADDR, (32'h1 << (8 + sel)) | dmab());
      // DMA-driven mode, request on elapse
      wr(`SYNC_MODE_ADDR, mw(2'h2, 1'b0, 3'h0, sy));
      repeat (3) ev(1'b1, 1'b0, 8'h0, 8'h0);
      cnt(8'h1, 8'h0, 8'h1);
      chk({17'h0, duty_val}, {17'h0, last_dma}, "duty value");
      rd(`IRQ2_STATUS_ADDR, 32'h1 | dmab());
      wr(`SYNC_TRIGGER_ADDR, 32'h1);
      ev(1'b1, 1'b0, 8'h0, 8'h0);
      cnt(8'h0, 8'h1, 8'h0);
      wr(`SYNC_PERIOD_BUF_ADDR, 32'h0);
      rd(`SYNC_PERIOD_ADDR, 32'h12);
      @(posedge clk_i);
      slow <= 1'b1;
      repeat (2) ev(1'b1, 1'b0, 8'h0, 8'h0);
      cnt(8'h1, 8'h0, 8'h1);
      chk({17'h0, duty_val}, {17'h0, last_dma}, "duty value");
      rd(`SYNC_PERIOD_ADDR, 32'h0);
      // DMA-driven mode, request on selected match
      rd(`IRQ2_STATUS_ADDR, 32'h1 | dmab());
      wr(`SYNC_MODE_ADDR, mw(2'h2, 1'b1, sel, sy));
      ev(1'b0, 1'b0, 8'h1 << sel, 8'h0);
      ev(1'b0, 1'b0, 8'h1 << oth, 8'h0);
      ev(1'b1, 1'b0, 8'h0, 8'h0);
      cnt(8'h1, 8'h0, 8'h1);
      ev(1'b0, 1'b1, 8'h0, 8'h1 << sel);
      rd(`IRQ2_STATUS_ADDR, 32'h9 | (32'h1 << (8 + sel)) | (32'h1 << (8 + oth))
         | (32'h1 << (16 + sel)) | dmab());
      rd(`IRQ2_STATUS_ADDR, dmab());
      // Reserved mode makes no update
      wr(`SYNC_MODE_ADDR, mw(2'h3, 1'b0, 3'h0, sy));
      repeat (2) ev(1'b1, 1'b0, 8'h0, 8'h0);
      cnt(8'h0, 8'h0, 8'h0);
      close_out();
   end
endmodule
